/* logic/floppy_status_output_tape_regs.sv */
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// =====================================================
// pin status, output control and tape registers of the
// floppy controller, reached over an AXI4-Lite slave
module floppy_status_output_tape_regs
  import floppy_regs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [3:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // configuration
  input  wire logic        master_reset_pin,
  input  wire logic        status_layout_two,
  input  wire logic        three_mode_enable,
  input  wire logic [7:0]  floppy_cfg_reg_f1,
  input  wire logic [7:0]  floppy_cfg_reg_f2,
  // drive interface levels seen by the block
  input  wire logic        write_pulse_out_n,
  input  wire logic        read_data_n,
  input  wire logic        write_gate_out_n,
  input  wire logic        motor_b_out_n,
  input  wire logic        second_drive_absent,
  input  wire logic        dma_req_in,
  input  wire logic        irq_in,
  // outputs steered by the registers
  output logic             motor_a_out_n,
  output logic             drive_a_select_out_n,
  output logic      [1:0]  drive_select,
  output logic             controller_reset_n,
  output logic             dma_req_out,
  output logic             irq_out,
  output logic      [1:0]  tape_select
);

  // =====================================================
  // storage

  // only bits 4:0 of output control are stored; the reserved bits are dropped
  logic [4:0] out_ctrl;
  logic [1:0] tape_sel;
  logic       write_gate_latch;
  logic [1:0] type_pair;

  // =====================================================
  // write channel state

  wr_state_t  wr_state;
  logic       aw_held;
  logic       w_held;
  logic [3:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic       w_lane0_q;
  logic       do_write;
  logic       write_ok;
  logic [1:0] write_idx;
  logic       wr_out_ctrl;
  logic       wr_tape;

  // =====================================================
  // read channel state

  logic       rd_pending;
  logic [7:0] read_value;
  logic       read_ok;
  logic [1:0] read_idx;
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic [7:0] tape_view;

  // =====================================================
  // drive select decode, shared by the select pin and layout two

  function automatic logic sel_is(input logic [1:0] sel, input logic [1:0] code);
    sel_is = (sel == code);
  endfunction

  // =====================================================
  // pin trackers for write data and read data
  // both lines idle high, so the samples reset high and no false edge follows reset

  edge_track_if wr_trk ();
  edge_track_if rd_trk ();

  assign wr_trk.pin_level = write_pulse_out_n;
  assign rd_trk.pin_level = read_data_n;

  pin_edge_tracker write_tracker (
    .aclk    (aclk),
    .aresetn (aresetn),
    .t       (wr_trk)
  );

  pin_edge_tracker read_tracker (
    .aclk    (aclk),
    .aresetn (aresetn),
    .t       (rd_trk)
  );

  // =====================================================
  // drive-type mirror follows the selected drive
  // master reset clears the select bits, so the mirror falls back to drive A

  drive_type_pick type_pick (
    .type_table (floppy_cfg_reg_f2),
    .drive_sel  (out_ctrl[1:0]),
    .type_pair  (type_pair)
  );

  // =====================================================
  // write address and data are taken in either order
  // both readies stay low while the answer waits, so a second write
  // can never overtake the first one

  assign awready = !aw_held && (wr_state == WR_IDLE);
  assign wready  = !w_held && (wr_state == WR_IDLE);

  // hold the address until its data partner arrives
  // the partner may come first; either half waits in its own flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (awvalid && awready) begin
      aw_held   <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (do_write) begin
      aw_held   <= 1'b0;
    end
  end

  // only the low byte lane carries register bits
  // upper lanes are ignored, since each register is eight bits wide
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held    <= 1'b0;
      w_byte_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_held    <= 1'b1;
      w_byte_q  <= wdata[7:0];
      w_lane0_q <= wstrb[0];
    end else if (do_write) begin
      w_held    <= 1'b0;
    end
  end

  // the register is written at the edge after the later half arrives
  assign do_write  = aw_held && w_held && (wr_state == WR_IDLE);
  assign write_idx = reg_index(aw_addr_q);
  // status register is read-only; writes there get an error
  assign write_ok  = addr_ok(aw_addr_q) && (write_idx != IDX_PIN_STATUS);

  // one strobe per writable register; a clear low lane strobe writes nothing
  assign wr_out_ctrl = do_write && write_ok && w_lane0_q && (write_idx == IDX_OUT_CTRL);
  assign wr_tape     = do_write && write_ok && w_lane0_q && (write_idx == IDX_TAPE);

  // response follows the cycle in which both halves are held
  // bresp settles at the same edge as bvalid and holds until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_IDLE;
      bresp    <= RESP_OKAY;
    end else begin
      case (wr_state)
        WR_IDLE: begin
          if (do_write) begin
            wr_state <= WR_RESP;
            bresp    <= write_ok ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (bready) begin
            wr_state <= WR_IDLE;
          end
        end
        default: wr_state <= WR_IDLE;
      endcase
    end
  end

  assign bvalid = (wr_state == WR_RESP);

  // =====================================================
  // output control register: master reset pin clears it
  // a write landing in the same cycle as master reset is lost; software
  // must repeat it once the pin is released

  always_ff @(posedge aclk) begin
    if (!aresetn || master_reset_pin) begin
      out_ctrl <= OUT_CTRL_RST[4:0];
    end else if (wr_out_ctrl) begin
      // reserved bits 7-5 are dropped
      out_ctrl <= w_byte_q[4:0] & OUT_CTRL_MASK;
    end
  end

  // =====================================================
  // tape select, writable in either tape layout
  // only aresetn clears it; the master reset pin reaches output control alone

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tape_sel <= TAPE_SEL_RST;
    end else if (wr_tape) begin
      // upper bits are reserved or read-only mirrors
      tape_sel <= w_byte_q[1:0];
    end
  end

  // =====================================================
  // outputs steered by the output control and tape select registers
  // these move at the edge at which the write lands, the edge at which bvalid rises

  assign motor_a_out_n      = ~out_ctrl[OUT_MOTOR_A];
  assign drive_select       = out_ctrl[1:0];
  assign controller_reset_n = out_ctrl[OUT_CTL_RUN];
  // the drive A select pin is only strobed while motor A runs
  assign drive_a_select_out_n = ~(out_ctrl[OUT_MOTOR_A] && sel_is(out_ctrl[1:0], 2'h0));
  // requests stay quiet until software enables them
  assign dma_req_out = dma_req_in & out_ctrl[OUT_DMA_INT];
  assign irq_out     = irq_in & out_ctrl[OUT_DMA_INT];
  // drive 0 never appears here; code 00 means no tape drive
  assign tape_select = tape_sel;

  // =====================================================
  // latched write gate for the second status layout
  // the latch adds one cycle of lag to layout two bit 2

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_gate_latch <= 1'b1;
    end else begin
      write_gate_latch <= write_gate_out_n;
    end
  end

  // =====================================================
  // status layout one view
  // the toggles count edges modulo two, so software compares two reads

  always_comb begin
    status_one      = 8'h00;
    status_one[7:6] = LAYOUT_ONE_HIGH;
    status_one[5]   = out_ctrl[0];
    status_one[4]   = wr_trk.flip;
    status_one[3]   = rd_trk.flip;
    status_one[2]   = ~write_gate_out_n;
    status_one[1]   = ~motor_b_out_n;
    status_one[0]   = ~motor_a_out_n;
  end

  // =====================================================
  // status layout two view; bits 1:0 show drive D and C selects
  // bit 5 is read back from the select pin, not from the register bit

  always_comb begin
    status_two    = 8'h00;
    status_two[7] = second_drive_absent;
    status_two[6] = LAYOUT_TWO_B6;
    status_two[5] = drive_a_select_out_n;
    status_two[4] = wr_trk.rise_latch_inv;
    status_two[3] = ~rd_trk.sampled;
    status_two[2] = ~write_gate_latch;
    status_two[1] = ~sel_is(out_ctrl[1:0], 2'h3);
    status_two[0] = ~sel_is(out_ctrl[1:0], 2'h2);
  end

  // =====================================================
  // tape register view in both layouts
  // the upper bits are live mirrors while three_mode_enable is set and read zero otherwise; writes only ever reach bits 1:0

  always_comb begin
    tape_view      = 8'h00;
    tape_view[1:0] = tape_sel;
    if (three_mode_enable) begin
      tape_view[7:6] = floppy_cfg_reg_f1[5:4];
      tape_view[5:4] = type_pair;
      tape_view[3:2] = floppy_cfg_reg_f1[7:6];
    end
  end

  // =====================================================
  // read mux; layout input is looked at per read, no reset needed

  assign read_idx = reg_index(araddr);
  // the output control register cannot be read back
  // such reads answer with zero data and an error response
  assign read_ok  = addr_ok(araddr) && (read_idx != IDX_OUT_CTRL);

  // pick the view of the register named by the read address
  always_comb begin
    read_value = 8'h00;
    case (read_idx)
      IDX_PIN_STATUS: read_value = status_layout_two ? status_two : status_one;
      IDX_TAPE:       read_value = tape_view;
      default:        read_value = 8'h00;
    endcase
  end

  // =====================================================
  // read channel: one read at a time, data one cycle after
  // arready drops while data waits, which keeps a single read in flight

  assign arready = !rd_pending;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pending <= 1'b0;
      rdata      <= 32'h0000_0000;
      rresp      <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rd_pending <= 1'b1;
      rdata      <= {24'h00_0000, (read_ok ? read_value : 8'h00)};
      rresp      <= read_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rd_pending && rready) begin
      rd_pending <= 1'b0;
    end
  end

  assign rvalid = rd_pending;

endmodule

/* logic/floppy_regs_pkg.sv */
package floppy_regs_pkg;

  // =====================================================
  // register indices (byte address is four times index)
  localparam logic [1:0] IDX_PIN_STATUS = 2'h1;
  localparam logic [1:0] IDX_OUT_CTRL   = 2'h2;
  localparam logic [1:0] IDX_TAPE       = 2'h3;

  // =====================================================
  // field positions of the output control register
  localparam int OUT_MOTOR_A = 4;
  localparam int OUT_DMA_INT = 3;
  localparam int OUT_CTL_RUN = 2;

  // =====================================================
  // reset values and fixed bits
  localparam logic [7:0] OUT_CTRL_RST    = 8'h00;
  localparam logic [4:0] OUT_CTRL_MASK   = 5'h1F;
  localparam logic [1:0] TAPE_SEL_RST    = 2'h0;
  localparam logic [1:0] LAYOUT_ONE_HIGH = 2'h3;
  localparam logic       LAYOUT_TWO_B6   = 1'b1;

  // =====================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  // register index from a byte address
  function automatic logic [1:0] reg_index(input logic [3:0] addr);
    reg_index = addr[3:2];
  endfunction

  // word aligned and inside the map
  function automatic logic addr_ok(input logic [3:0] addr);
    addr_ok = (addr[1:0] == 2'h0) && (addr[3:2] != 2'h0);
  endfunction

endpackage

/* logic/edge_track_if.sv */
`timescale 1ns/10ps
// =====================================================
// carrier between a pin tracker and its user
interface edge_track_if;
  logic pin_level;
  logic sampled;
  logic flip;
  logic rise_latch_inv;

  modport tracker (input pin_level, output sampled, output flip, output rise_latch_inv);
  modport user    (output pin_level, input sampled, input flip, input rise_latch_inv);
endinterface

/* logic/pin_edge_tracker.sv */
`timescale 1ns/10ps
// =====================================================
// samples an active-low pin, toggles and latches on rise
module pin_edge_tracker
  import floppy_regs_pkg::*;
(
  input wire logic     aclk,
  input wire logic     aresetn,
  edge_track_if.tracker t
);

  logic rise;

  // idle level of these pins is high, so the sample starts high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t.sampled <= 1'b1;
    end else begin
      t.sampled <= t.pin_level;
    end
  end

  assign rise = t.pin_level & ~t.sampled;

  // toggle on every rising transition
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t.flip <= 1'b0;
    end else if (rise) begin
      t.flip <= ~t.flip;
    end
  end

  // capture inverse of the level held just before the rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t.rise_latch_inv <= 1'b0;
    end else if (rise) begin
      t.rise_latch_inv <= ~t.sampled;
    end
  end

endmodule

/* logic/drive_type_pick.sv */
`timescale 1ns/10ps
// =====================================================
// picks the drive-type pair of the selected drive
module drive_type_pick
  import floppy_regs_pkg::*;
(
  input  wire logic [7:0] type_table,
  input  wire logic [1:0] drive_sel,
  output logic      [1:0] type_pair
);

  // two bits per drive, drive A in the low pair
  always_comb begin
    case (drive_sel)
      2'h0:    type_pair = type_table[1:0];
      2'h1:    type_pair = type_table[3:2];
      2'h2:    type_pair = type_table[5:4];
      default: type_pair = type_table[7:6];
    endcase
  end

endmodule

/* tb/floppy_regs_sva.sv */
`timescale 1ns/10ps
// =====================================================
// port checker for the floppy register slice
module floppy_regs_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [3:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        master_reset_pin,
  input wire logic        dma_req_in,
  input wire logic        dma_req_out,
  input wire logic        motor_a_out_n,
  input wire logic        drive_a_select_out_n,
  input wire logic [1:0]  drive_select,
  input wire logic        controller_reset_n,
  input wire logic [1:0]  tape_select
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // =====================================================
  // outputs after reset and master reset
  property p_rst;
    $rose(aresetn) |-> motor_a_out_n && drive_a_select_out_n && drive_select == 2'h0 && !controller_reset_n;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_mrst;
    master_reset_pin |=> motor_a_out_n && drive_select == 2'h0 && !controller_reset_n;
  endproperty
  a_mrst: assert property (p_mrst) else $error("master reset did not clear control");
  // =====================================================
  // gating and select decode
  property p_dma;
    !dma_req_in |-> !dma_req_out;
  endproperty
  a_dma: assert property (p_dma) else $error("request out without request in");
  property p_dsa;
    !drive_a_select_out_n |-> drive_select == 2'h0 && !motor_a_out_n;
  endproperty
  a_dsa: assert property (p_dsa) else $error("drive A select with other drive");
  // =====================================================
  // register outputs move only with a write answer or master reset
  property p_sel;
    $changed(drive_select) |-> $rose(bvalid) || $past(master_reset_pin);
  endproperty
  a_sel: assert property (p_sel) else $error("drive select changed without write");
  property p_tape;
    $changed(tape_select) |-> $rose(bvalid);
  endproperty
  a_tape: assert property (p_tape) else $error("tape select changed without write");
  property p_crn;
    $rose(controller_reset_n) |-> $rose(bvalid);
  endproperty
  a_crn: assert property (p_crn) else $error("controller released without write");
  // =====================================================
  // bus answers
  property p_ro;
    awvalid && awready && wvalid && wready && awaddr == 4'h4 |-> ##2 bvalid && bresp == 2'h2;
  endproperty
  a_ro: assert property (p_ro) else $error("status write not refused");
  property p_rhi;
    rvalid |-> rdata[31:8] == 24'h0;
  endproperty
  a_rhi: assert property (p_rhi) else $error("upper read data not zero");
  c_err: cover property (bvalid && bresp == 2'h2);
  c_run: cover property ($rose(controller_reset_n));
  c_mrst: cover property (master_reset_pin);
endmodule

bind floppy_status_output_tape_regs floppy_regs_sva chk (.*);

/* tb/drive_pins_model.sv */
`timescale 1ns/10ps
// =====================================================
// drive-side pin levels; lines idle high between pulses
module drive_pins_model (
  input  wire logic aclk,
  output logic      write_pulse_out_n,
  output logic      read_data_n,
  output logic      write_gate_out_n,
  output logic      motor_b_out_n,
  output logic      second_drive_absent
);
  // all lines inactive, second drive present
  initial begin
    write_pulse_out_n = 1'b1;
    read_data_n = 1'b1;
    write_gate_out_n = 1'b1;
    motor_b_out_n = 1'b1;
    second_drive_absent = 1'b0;
  end

  // n low pulses of two cycles; wr picks the write or read line
  task automatic pulse(input bit wr, input int n);
    repeat (n) begin
      @(posedge aclk);
      if (wr) write_pulse_out_n <= 1'b0;
      else read_data_n <= 1'b0;
      repeat (2) @(posedge aclk);
      if (wr) write_pulse_out_n <= 1'b1;
      else read_data_n <= 1'b1;
      @(posedge aclk);
    end
  endtask

  // static levels of write gate, motor B and drive presence
  task automatic levels(input logic wg, input logic mb, input logic ab);
    @(posedge aclk);
    write_gate_out_n <= wg;
    motor_b_out_n <= mb;
    second_drive_absent <= ab;
  endtask
endmodule

/* tb/floppy_status_output_tape_regs_tb.sv */
`timescale 1ns/10ps
// =====================================================
// self-checking bench for the floppy register slice
module floppy_status_output_tape_regs_tb;
  import floppy_regs_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  awaddr, araddr;
  logic [3:0]  wstrb = 4'hF;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata, rdata, r;
  logic [1:0]  bresp, rresp, drive_select, tape_select, ts;
  logic [7:0]  floppy_cfg_reg_f1, floppy_cfg_reg_f2, v;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        master_reset_pin, status_layout_two, three_mode_enable, dma_req_in, irq_in;
  logic        write_pulse_out_n, read_data_n, write_gate_out_n, motor_b_out_n, second_drive_absent;
  logic        motor_a_out_n, drive_a_select_out_n, controller_reset_n, dma_req_out, irq_out;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          num_errors = 0;
  int          n_tests = 0;

  floppy_status_output_tape_regs dut (.*);
  drive_pins_model pm (.*);

  // 20 MHz clock
  always #25 aclk = ~aclk;

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e);
    bq.push_back(e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] e);
    rq.push_back({e, 24'h0, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic cfg(input logic lay, input logic tm);
    @(posedge aclk);
    status_layout_two <= lay;
    three_mode_enable <= tm;
  endtask

  task automatic pins(input logic [8:0] e);
    chk({25'h0, motor_a_out_n, drive_a_select_out_n, drive_select, controller_reset_n, dma_req_out, irq_out,
         tape_select}, {25'h0, e});
  endtask

  // answers are matched against the oldest expectation at each handshake
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
  end

  // a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    results();
  end

  initial begin
    void'($urandom(31469));
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {master_reset_pin, status_layout_two, three_mode_enable, dma_req_in, irq_in} = '0;
    floppy_cfg_reg_f1 = 8'h00;
    floppy_cfg_reg_f2 = 8'h03;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    pins(9'h180);
    rd(4'h4, 8'hC0, RESP_OKAY);
    cfg(1'b1, 1'b1);
    rd(4'h4, 8'h63, RESP_OKAY);
    rd(4'hC, 8'h30, RESP_OKAY);
    cfg(1'b0, 1'b0);
    rd(4'hC, 8'h00, RESP_OKAY);
    rd(4'h8, 8'h00, RESP_SLVERR);
    rd(4'h0, 8'h00, RESP_SLVERR);
    // every drive select and tape code, random control bits and mirrors
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      v = {r[7:2], i[1:0]};
      ts = ~i[1:0];
      @(posedge aclk);
      dma_req_in <= r[8];
      irq_in <= r[9];
      floppy_cfg_reg_f1 <= r[23:16];
      floppy_cfg_reg_f2 <= r[31:24];
      wr(4'h8, v, RESP_OKAY);
      wr(4'hC, {r[15:10], ts}, RESP_OKAY);
      pins({~v[4], ~(v[4] && i == 0), v[1:0], v[2], r[8] & v[3], r[9] & v[3], ts});
      rd(4'h4, {2'h3, v[0], 4'h0, v[4]}, RESP_OKAY);
      rd(4'hC, {6'h0, ts}, RESP_OKAY);
      cfg(1'b1, 1'b1);
      rd(4'h4, {2'h1, ~(v[4] && i == 0), 3'h0, i != 3, i != 2}, RESP_OKAY);
      rd(4'hC, {r[21:20], r[24 + 2 * i +: 2], r[23:22], ts}, RESP_OKAY);
      cfg(1'b0, 1'b0);
    end
    // odd write pulse count, even read pulse count, gate and motor B on
    fork
      pm.pulse(1'b1, 3);
      pm.pulse(1'b0, 2);
    join
    pm.levels(1'b0, 1'b0, 1'b1);
    repeat (3) @(posedge aclk);
    rd(4'h4, {4'hF, 3'h3, v[4]}, RESP_OKAY);
    // one more read pulse makes the read toggle odd
    pm.pulse(1'b0, 1);
    rd(4'h4, {7'h7F, v[4]}, RESP_OKAY);
    cfg(1'b1, 1'b0);
    rd(4'h4, 8'hF5, RESP_OKAY);
    // read line held low across the address edge shows in bit 3
    fork
      pm.pulse(1'b0, 1);
      begin
        @(posedge aclk);
        rd(4'h4, 8'hFD, RESP_OKAY);
      end
    join
    wr(4'h4, 8'hFF, RESP_SLVERR);
    wr(4'h9, 8'hFF, RESP_SLVERR);
    wr(4'h8, 8'h1C, RESP_OKAY);
    pins({2'h0, 2'h0, 1'b1, dma_req_in, irq_in, ts});
    // a write with the low lane strobe clear is answered but changes nothing
    wstrb <= 4'hE;
    wr(4'h8, 8'h03, RESP_OKAY);
    wstrb <= 4'hF;
    pins({2'h0, 2'h0, 1'b1, dma_req_in, irq_in, ts});
    // master reset clears control only; tape select survives
    @(posedge aclk);
    master_reset_pin <= 1'b1;
    @(posedge aclk);
    master_reset_pin <= 1'b0;
    @(posedge aclk);
    pins({2'h3, 2'h0, 3'h0, ts});
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    pins(9'h180);
    rd(4'hC, 8'h00, RESP_OKAY);
    results();
  end
endmodule
